/* File: core/cps_pkg.sv */
// Package: constants, types and state layout of the program sequencer
package cps_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int PC_W        = 12;
	localparam int DATA_W      = 8;
	localparam int INSTR_W     = 16;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W        = 3;
	localparam int CNT_W       = 4;
	localparam int ADDR_W      = 8;

	// ************************************************************
	// Register map and reset values
	// ************************************************************
	localparam logic [ADDR_W-1:0] PCLOW_OFS  = 8'h00;
	localparam logic [ADDR_W-1:0] ACC_OFS    = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
	localparam logic [PC_W-1:0]   PC_RST     = 12'h000;
	localparam logic [SP_W-1:0]   SP_RST     = 3'h0;
	localparam logic [CNT_W-1:0]  STACK_FULL = 4'h8;

	// Status flag positions
	localparam int C_BIT  = 0;
	localparam int AC_BIT = 1;
	localparam int Z_BIT  = 2;
	localparam int OV_BIT = 3;
	localparam int PH_LSB = 4;

	// ************************************************************
	// Enumerations
	// ************************************************************
	typedef enum logic [1:0] {PH_T1 = 2'b00, PH_T2 = 2'b01, PH_T3 = 2'b10, PH_T4 = 2'b11}
		cps_phase_e;
	typedef enum logic [2:0] {K_NOP = 3'b000, K_ALU = 3'b001, K_JUMP = 3'b010,
		K_CALL = 3'b011, K_RETURN = 3'b100, K_RETURN_INT = 3'b101} cps_kind_e;
	typedef enum logic [3:0] {ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
		ALU_DECADJ = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7, ALU_CPL = 4'h8,
		ALU_RR = 4'h9, ALU_RRC = 4'hA, ALU_RL = 4'hB, ALU_RLC = 4'hC, ALU_INC = 4'hD,
		ALU_DEC = 4'hE, ALU_PASS = 4'hF} cps_alu_e;
	typedef enum logic [1:0] {SK_NONE = 2'b00, SK_ZERO = 2'b01, SK_NZERO = 2'b10} cps_skip_e;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		cps_kind_e        kind;
		logic             ext;
		cps_alu_e         op;
		logic             dst_acc;
		cps_skip_e        skip;
		logic [PC_W-1:0]  target;
	} cps_dec_s;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} cps_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} cps_apb_rsp_s;

	typedef struct packed {
		logic [DATA_W-1:0] res;
		logic              c;
		logic              ac;
		logic              z;
		logic              ov;
	} cps_alu_s;

	typedef struct packed {
		cps_phase_e                           ph;
		logic [PC_W-1:0]                      pc;
		logic [INSTR_W-1:0]                   fetch;
		logic                                 fetch_vld;
		logic [INSTR_W-1:0]                   exec;
		logic                                 exec_vld;
		logic                                 ext_half;
		logic                                 hold;
		logic [STACK_DEPTH-1:0][PC_W-1:0]     stack;
		logic [SP_W-1:0]                      sp;
		logic [CNT_W-1:0]                     count;
		logic [DATA_W-1:0]                    acc;
		logic [3:0]                           status;
		logic                                 irq_pend;
		logic                                 int_ack;
		logic                                 pclow_pend;
		logic [DATA_W-1:0]                    pclow_val;
		logic                                 mem_wr;
		logic [DATA_W-1:0]                    mem_wdata;
		logic [31:0]                          prdata;
	} cps_state_s;

	localparam cps_state_s STATE_RST = '0;

endpackage : cps_pkg

/* File: core/cps_core.sv */
// Module: instruction phase sequencer, program counter, return stack and ALU
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE_01: Four phases make one instruction cycle.
// RULE_02: Counter advances and fetch happens in first phase.
// RULE_03: Decode and execute over phases two to four.
// RULE_04: Fetch overlaps execution; extended takes two cycles.
// RULE_05: Jump and call take one extra cycle.
// RULE_06: Twelve-bit counter; low byte software accessible.
// RULE_07: Counter increments unless control is transferred.
// RULE_08: Jump, call, interrupt, reset load target directly.
// RULE_09: Taken skip replaces fetched instruction with dummy.
// RULE_10: Low byte write jumps in page, dummy cycle.
// RULE_11: Eight-level hidden stack of counter values.
// RULE_12: Call or interrupt acknowledge pushes counter.
// RULE_13: Return pops stack into counter.
// RULE_14: Reset sets stack pointer to top.
// RULE_15: Full stack holds interrupt until a return.
// RULE_16: Call on full stack overwrites oldest entry.
// RULE_17: Eight-bit ALU with accumulator data path.
// RULE_18: ALU writes destination and updates status flags.
// RULE_19: ALU does arithmetic, logic, rotate, step, skip.
// RULE_20: Low byte write keeps upper counter bits.
module cps_core
#(
	parameter logic [cps_pkg::PC_W-1:0] INT_VECTOR = 12'h004
)
(
	// Clock, reset, enable
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         ce,
	// APB slave
	input  wire cps_pkg::cps_apb_req_s        apb_req,
	output cps_pkg::cps_apb_rsp_s             apb_rsp,
	// Program memory
	output logic [cps_pkg::PC_W-1:0]          pmem_addr,
	output logic                              pmem_rd,
	input  wire logic [cps_pkg::INSTR_W-1:0]  pmem_data,
	// Decoder and data memory
	output logic [cps_pkg::INSTR_W-1:0]       exec_word,
	output logic                              exec_valid,
	input  wire cps_pkg::cps_dec_s            dec_in,
	input  wire logic [cps_pkg::DATA_W-1:0]   operand_in,
	output logic                              mem_wr,
	output logic [cps_pkg::DATA_W-1:0]        mem_wdata,
	// Interrupt handshake and status
	input  wire logic                         irq_req,
	input  wire logic                         gie,
	output logic                              int_ack,
	output logic [3:0]                        status_flags
);
	import cps_pkg::*;

	// ************************************************************
	// ALU
	// ************************************************************
	// Rotates, steps and complement act on the operand; arithmetic on acc and operand
	function automatic cps_alu_s alu_fn(input cps_alu_e op, input logic [7:0] a,
		input logic [7:0] b, input logic [3:0] st);
		cps_alu_s    o;
		logic [8:0]  w;
		logic [4:0]  h;
		logic        ci;
		o.res = b;
		o.c = st[C_BIT];
		o.ac = st[AC_BIT];
		o.ov = st[OV_BIT];
		o.z = 1'b0;
		w = 9'h000;
		h = 5'h00;
		ci = st[C_BIT];
		case (op)
			ALU_ADD, ALU_ADC:
			begin
				w = {1'b0, a} + {1'b0, b} + {8'h00, (op == ALU_ADC) & ci};
				h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == ALU_ADC) & ci};
				o.res = w[7:0];
				o.c = w[8];
				o.ac = h[4];
				o.ov = (a[7] == b[7]) && (w[7] != a[7]);
			end
			ALU_SUB, ALU_SBC:
			begin
				// Carry set means no borrow
				w = {1'b0, a} + {1'b0, ~b} + {8'h00, (op == ALU_SUB) | ci};
				h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, (op == ALU_SUB) | ci};
				o.res = w[7:0];
				o.c = w[8];
				o.ac = h[4];
				o.ov = (a[7] != b[7]) && (w[7] != a[7]);
			end
			ALU_DECADJ:
			begin
				w = {1'b0, a};
				if ((a[3:0] > 4'h9) || st[AC_BIT])
				begin
					w = w + 9'h006;
				end
				if ((w[7:4] > 4'h9) || st[C_BIT] || w[8])
				begin
					w = w + 9'h060;
				end
				o.res = w[7:0];
				o.c = st[C_BIT] | w[8];
			end
			ALU_AND:  o.res = a & b;
			ALU_OR:   o.res = a | b;
			ALU_XOR:  o.res = a ^ b;
			ALU_CPL:  o.res = ~b;
			ALU_RR:   o.res = {b[0], b[7:1]};
			ALU_RRC:
			begin
				o.res = {ci, b[7:1]};
				o.c = b[0];
			end
			ALU_RL:   o.res = {b[6:0], b[7]};
			ALU_RLC:
			begin
				o.res = {b[6:0], ci};
				o.c = b[7];
			end
			ALU_INC:  o.res = b + 8'h01;
			ALU_DEC:  o.res = b - 8'h01;
			default:  o.res = b;
		endcase
		o.z = (o.res == 8'h00);
		return o;
	endfunction : alu_fn

	// ************************************************************
	// State
	// ************************************************************
	cps_state_s      r_reg;
	cps_state_s      r_next;
	cps_alu_s        alu;
	logic            redirect;
	logic            skip_hit;
	logic            irq_take;
	logic [PC_W-1:0] tgt;
	logic [PC_W-1:0] ret_addr;
	logic [PC_W-1:0] stack_top;
	logic            apb_setup;
	logic            apb_access;
	logic            addr_ok;

	assign stack_top  = r_reg.stack[r_reg.sp - SP_W'(1)]; // RULE_11
	assign ret_addr   = r_reg.pc - PC_W'(1);
	assign alu        = alu_fn(dec_in.op, r_reg.acc, operand_in, r_reg.status);
	assign apb_setup  = apb_req.psel && !apb_req.penable;
	assign apb_access = apb_req.psel && apb_req.penable;
	assign addr_ok    = (apb_req.paddr == PCLOW_OFS) || (apb_req.paddr == ACC_OFS) ||
		(apb_req.paddr == STATUS_OFS);

	// Next-state logic: phases, fetch, execute, stack and register access
	always_comb
	begin
		r_next = r_reg;
		redirect = 1'b0;
		skip_hit = 1'b0;
		irq_take = 1'b0;
		tgt = r_reg.pc;
		if (ce)
		begin
			r_next.mem_wr = 1'b0;
			r_next.int_ack = 1'b0;
			// Four phases per instruction cycle
			case (r_reg.ph)
				PH_T1:   r_next.ph = PH_T2; // RULE_01
				PH_T2:   r_next.ph = PH_T3;
				PH_T3:   r_next.ph = PH_T4;
				PH_T4:   r_next.ph = PH_T1;
				default: r_next.ph = PH_T1;
			endcase
			// First phase: step counter and fetch the next word
			if (r_reg.ph == PH_T1 && !r_reg.hold)
			begin
				r_next.pc = r_reg.pc + PC_W'(1); // RULE_02 RULE_07
				r_next.fetch = pmem_data; // RULE_04
				r_next.fetch_vld = 1'b1;
			end
			// Last phase: the instruction in execute completes
			if (r_reg.ph == PH_T4)
			begin
				if (r_reg.exec_vld && dec_in.ext && !r_reg.ext_half)
				begin
					// Extended work spans a second cycle, pipeline stalls
					r_next.ext_half = 1'b1; // RULE_04
					r_next.hold = 1'b1;
				end
				else
				begin
					r_next.ext_half = 1'b0;
					r_next.hold = 1'b0;
					if (r_reg.exec_vld)
					begin
						case (dec_in.kind)
							K_ALU:
							begin
								r_next.status[C_BIT] = alu.c; // RULE_18
								r_next.status[AC_BIT] = alu.ac;
								r_next.status[Z_BIT] = alu.z;
								r_next.status[OV_BIT] = alu.ov;
								if (dec_in.dst_acc)
								begin
									r_next.acc = alu.res; // RULE_17
								end
								else
								begin
									r_next.mem_wr = 1'b1;
									r_next.mem_wdata = alu.res;
								end
								skip_hit = (dec_in.skip == SK_ZERO && alu.z) ||
									(dec_in.skip == SK_NZERO && !alu.z); // RULE_19
							end
							K_JUMP:
							begin
								redirect = 1'b1; // RULE_05
								tgt = dec_in.target; // RULE_08
							end
							K_CALL:
							begin
								// Full stack wraps over the oldest entry
								r_next.stack[r_reg.sp] = ret_addr; // RULE_12 RULE_16
								r_next.sp = r_reg.sp + SP_W'(1);
								if (r_reg.count != STACK_FULL)
								begin
									r_next.count = r_reg.count + CNT_W'(1);
								end
								redirect = 1'b1;
								tgt = dec_in.target;
							end
							K_RETURN, K_RETURN_INT:
							begin
								tgt = stack_top; // RULE_13
								r_next.sp = r_reg.sp - SP_W'(1);
								if (r_reg.count != '0)
								begin
									r_next.count = r_reg.count - CNT_W'(1);
								end
								redirect = 1'b1;
							end
							default: redirect = 1'b0;
						endcase
					end
					// Low byte write jumps inside the current page
					if (r_reg.pclow_pend && !redirect)
					begin
						tgt = {r_reg.pc[PC_W-1:DATA_W], r_reg.pclow_val}; // RULE_10 RULE_20
						redirect = 1'b1;
					end
					if (r_reg.pclow_pend)
					begin
						r_next.pclow_pend = 1'b0;
					end
					// Acknowledge held off while every stack level is used
					irq_take = r_reg.irq_pend && gie && !redirect && !skip_hit &&
						(r_reg.count != STACK_FULL); // RULE_15
					if (irq_take)
					begin
						r_next.stack[r_reg.sp] = ret_addr; // RULE_12
						r_next.sp = r_reg.sp + SP_W'(1);
						r_next.count = r_reg.count + CNT_W'(1);
						r_next.irq_pend = 1'b0;
						r_next.int_ack = 1'b1;
						tgt = INT_VECTOR; // RULE_08
						redirect = 1'b1;
					end
					// Shift the pipeline; a redirect or skip leaves a dummy cycle
					r_next.exec = r_reg.fetch;
					r_next.exec_vld = r_reg.fetch_vld && !redirect && !skip_hit; // RULE_09
					if (redirect)
					begin
						r_next.pc = tgt;
					end
				end
			end
			// Request flag: a new request wins over the acknowledge clear
			if (irq_req)
			begin
				r_next.irq_pend = 1'b1; // RULE_15
			end
			// APB read data is captured in the setup cycle
			if (apb_setup)
			begin
				case (apb_req.paddr)
					PCLOW_OFS:  r_next.prdata = {24'h000000, r_reg.pc[DATA_W-1:0]}; // RULE_06
					ACC_OFS:    r_next.prdata = {24'h000000, r_reg.acc};
					STATUS_OFS: r_next.prdata = {26'h0000000, r_reg.ph, r_reg.status};
					default:    r_next.prdata = 32'h00000000;
				endcase
			end
			// APB writes take effect at the access edge; set wins over clear
			if (apb_access && apb_req.pwrite)
			begin
				if (apb_req.paddr == PCLOW_OFS)
				begin
					r_next.pclow_pend = 1'b1; // RULE_10
					r_next.pclow_val = apb_req.pwdata[DATA_W-1:0];
				end
				if (apb_req.paddr == ACC_OFS)
				begin
					r_next.acc = apb_req.pwdata[DATA_W-1:0];
				end
			end
		end
	end

	// State register; reset clears the stack pointer to zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg <= STATE_RST; // RULE_14
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Ready follows enable so a frozen block stalls the bus instead of dropping it
	assign apb_rsp.pready  = ce;
	assign apb_rsp.prdata  = r_reg.prdata;
	assign apb_rsp.pslverr = apb_access && !addr_ok;
	assign pmem_addr       = r_reg.pc;
	assign pmem_rd         = ce && (r_reg.ph == PH_T1) && !r_reg.hold; // RULE_02
	assign exec_word       = r_reg.exec; // RULE_03
	assign exec_valid      = r_reg.exec_vld;
	assign mem_wr          = r_reg.mem_wr;
	assign mem_wdata       = r_reg.mem_wdata;
	assign int_ack         = r_reg.int_ack;
	assign status_flags    = r_reg.status;

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_t4_exec(cps_kind_e k);
		ce && r_reg.ph == PH_T4 && r_reg.exec_vld && !dec_in.ext && dec_in.kind == k;
	endsequence

	sequence s_skip_hit;
		ce && r_reg.ph == PH_T4 && skip_hit;
	endsequence

	a_phase_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
		ce && r_reg.ph == PH_T4 |=> r_reg.ph == PH_T1)
		else $error("phase did not return to first phase");

	a_fetch_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
		pmem_rd |=> r_reg.pc == $past(r_reg.pc) + PC_W'(1) && r_reg.ph == PH_T2)
		else $error("counter did not step after fetch");

	a_write_t4: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
		$rose(mem_wr) |-> r_reg.ph == PH_T1 && $past(r_reg.ph) == PH_T4)
		else $error("result written outside last phase");

	a_jump_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
		s_t4_exec(K_JUMP) |=> r_reg.pc == $past(dec_in.target) && !r_reg.exec_vld)
		else $error("jump target not loaded or no dummy cycle");

	a_call_push: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
		s_t4_exec(K_CALL) |=> r_reg.stack[$past(r_reg.sp)] == $past(r_reg.pc) - PC_W'(1)
		&& r_reg.sp == $past(r_reg.sp) + SP_W'(1))
		else $error("call did not push return address");

	a_ret_pop: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
		s_t4_exec(K_RETURN) |=> r_reg.pc == $past(stack_top))
		else $error("return did not restore counter");

	a_full_noack: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
		r_reg.count == STACK_FULL && ce && r_reg.ph == PH_T4 |=> !int_ack)
		else $error("interrupt acknowledged on full stack");

	a_skip_dummy: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
		s_skip_hit |=> !r_reg.exec_vld ##4 (r_reg.exec_vld == $past(r_reg.fetch_vld) || int_ack ||
		!$past(ce) || $past(r_reg.ph) != PH_T4 || $past(r_reg.pclow_pend)))
		else $error("taken skip did not insert a dummy cycle");

	a_pclow_page: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
		ce && r_reg.ph == PH_T4 && r_reg.pclow_pend && !(r_reg.exec_vld && ((dec_in.ext &&
		!r_reg.ext_half) || dec_in.kind inside {K_JUMP, K_CALL, K_RETURN, K_RETURN_INT}))
		|=> r_reg.pc == {$past(r_reg.pc[PC_W-1:DATA_W]), $past(r_reg.pclow_val)})
		else $error("low byte write left the page");

endmodule : cps_core

`default_nettype wire

/* File: tb/cps_pmem_model.sv */
// Program memory model answering instruction fetches of the sequencer
`timescale 1ns/10ps
`default_nettype none

module cps_pmem_model
	import cps_pkg::*;
(
	// Fetch request and answer
	input  wire logic [cps_pkg::PC_W-1:0]    pmem_addr,
	input  wire logic                        pmem_rd,
	output logic [cps_pkg::INSTR_W-1:0]      pmem_data
);
	import cps_pkg::*;

	// Word store, patched by the bench while the core runs
	logic [INSTR_W-1:0] rom [0:(1<<PC_W)-1];

	initial
	begin
		for (int i = 0; i < (1<<PC_W); i++) rom[i] = 16'h0000;
	end

	// Valid only during a fetch; otherwise the inverse, so a late sample shows up
	assign pmem_data = pmem_rd ? rom[pmem_addr] : ~rom[pmem_addr];

endmodule : cps_pmem_model

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the program sequencer
`timescale 1ns/10ps
`default_nettype none

module tb;
	import cps_pkg::*;

	// ************************************************************
	// Signals
	// ************************************************************
	localparam logic [PC_W-1:0] VEC = 12'h004;
	logic                  pclk;
	logic                  presetn;
	logic                  ce;
	cps_apb_req_s          req;
	cps_apb_rsp_s          rsp;
	logic [PC_W-1:0]       pmem_addr;
	logic                  pmem_rd;
	logic [INSTR_W-1:0]    pmem_data;
	logic [INSTR_W-1:0]    exec_word;
	logic                  exec_valid;
	cps_dec_s              dec;
	logic [DATA_W-1:0]     operand;
	logic                  mem_wr;
	logic [DATA_W-1:0]     mem_wdata;
	logic                  irq_req;
	logic                  gie;
	logic                  int_ack;
	logic [3:0]            status_flags;
	int                    n_fail;
	int                    n_checks;
	int                    n_acks;
	int                    gap;
	logic [PC_W-1:0]       fq[$];
	logic [31:0]           rd;
	logic [31:0]           s;
	logic                  err;

	cps_core #(.INT_VECTOR(VEC)) u_cps_core (.pclk(pclk), .presetn(presetn), .ce(ce),
		.apb_req(req), .apb_rsp(rsp), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
		.pmem_data(pmem_data), .exec_word(exec_word), .exec_valid(exec_valid),
		.dec_in(dec), .operand_in(operand), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.irq_req(irq_req), .gie(gie), .int_ack(int_ack), .status_flags(status_flags));
	cps_pmem_model u_cps_pmem_model (.pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
		.pmem_data(pmem_data));

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// Bench decoder: kind, destination, op, skip and target sit in fixed word fields
	always_comb
	begin
		dec.kind    = cps_kind_e'(exec_word[15:13]);
		dec.ext     = 1'b0;
		dec.op      = cps_alu_e'(exec_word[11:8]);
		dec.dst_acc = exec_word[12];
		dec.skip    = cps_skip_e'(exec_word[7:6]);
		dec.target  = exec_word[11:0];
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic bad(input string m);
		n_fail++;
		$display("BAD %0t %s", $time, m);
	endtask : bad

	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) bad(m);
	endtask : expect_eq

	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		// Only the watchdog ends a wait for ready
		do
		begin
			@(posedge pclk);
		end
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	// Wait, bounded, until n fetches are recorded
	task automatic wait_q(input int n);
		for (int i = 0; i < 400 && fq.size() < n; i++) @(negedge pclk);
		if (fq.size() < n) bad("fetch wait ran out");
	endtask : wait_q

	// Fetch recorder; an acknowledge restarts the record so the vector fetch comes first
	// Sampled mid-cycle so outputs launched at the rising edge have settled
	always @(negedge pclk)
	begin
		if (presetn !== 1'b1) gap = 0;
		else
		begin
			if (int_ack === 1'b1)
			begin
				n_acks++;
				fq.delete();
			end
			if (pmem_rd === 1'b1)
			begin
				if (gap != 0) expect_eq(gap, 4, "fetch spacing");
				gap = 1;
				fq.push_back(pmem_addr);
			end
			else if (gap != 0) gap++;
		end
	end

	// Timeout far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge pclk);
		bad("timeout");
		finish_test();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		logic [PC_W-1:0] seq [10];
		cps_alu_e        ops [10];
		logic [7:0]      av [10];
		logic [7:0]      bv [10];
		logic [7:0]      ev [10];
		int              cnt;
		seq = '{12'h000, 12'h001, 12'h010, 12'h011, 12'h012, 12'h013, 12'h001, 12'h002,
			12'h020, 12'h021};
		ops = '{ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL, ALU_INC, ALU_DEC,
			ALU_RL, ALU_ADC};
		av = '{8'hF0, 8'h30, 8'h3C, 8'h3C, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0};
		bv = '{8'h20, 8'h10, 8'h0F, 8'h0F, 8'h0F, 8'hA5, 8'hFF, 8'h00, 8'h81, 8'h20};
		ev = '{8'h10, 8'h20, 8'h0C, 8'h3F, 8'h33, 8'h5A, 8'h00, 8'hFF, 8'h03, 8'h11};
		presetn = 1'b0;
		ce = 1'b1;
		req = '0;
		operand = 8'h00;
		irq_req = 1'b0;
		gie = 1'b0;
		n_fail = 0;
		n_checks = 0;
		@(posedge pclk);
		// Call, skip, return, jump, then a call to itself that overflows the stack
		u_cps_pmem_model.rom[12'h000] = 16'h6010;
		u_cps_pmem_model.rom[12'h001] = 16'h4020;
		u_cps_pmem_model.rom[12'h004] = 16'h43F0;
		u_cps_pmem_model.rom[12'h010] = 16'h2F40;
		u_cps_pmem_model.rom[12'h011] = 16'h40FF;
		u_cps_pmem_model.rom[12'h012] = 16'h8000;
		u_cps_pmem_model.rom[12'h020] = 16'h6020;
		u_cps_pmem_model.rom[12'h101] = 16'h4100;
		u_cps_pmem_model.rom[12'h3B0] = 16'h4100;
		repeat (9) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		expect_eq(exec_valid, 1'b0, "execute before first fetch");
		repeat (4) @(negedge pclk);
		expect_eq(exec_valid, 1'b1, "execute after one cycle");
		wait_q(10);
		for (int k = 0; k < 10; k++) expect_eq(fq[k], seq[k], "fetch order");
		// Overflowing calls keep running
		repeat (200) @(posedge pclk);
		@(negedge pclk);
		fq.delete();
		wait_q(4);
		for (int k = 0; k < 4; k++) expect_eq({fq[k][11:1], 1'b0}, 12'h020, "overflow call");
		// Registers
		apb(1'b0, PCLOW_OFS, 32'h0);
		expect_eq({31'h0, rd >= 32'h20 && rd <= 32'h22}, 32'h1, "counter low read");
		apb(1'b0, ACC_OFS, 32'h0);
		expect_eq(rd, 32'h0, "acc reset");
		apb(1'b1, ACC_OFS, 32'h5A);
		apb(1'b0, ACC_OFS, 32'h0);
		expect_eq(rd, 32'h5A, "acc write");
		apb(1'b0, STATUS_OFS, 32'h0);
		s = rd;
		apb(1'b1, STATUS_OFS, 32'hF);
		apb(1'b0, STATUS_OFS, 32'h0);
		expect_eq(rd[3:0], s[3:0], "status read only");
		expect_eq(rd[3:0], status_flags, "status port");
		apb(1'b1, 8'h0C, 32'hFF);
		expect_eq(err, 1'b1, "unmapped error");
		apb(1'b0, 8'h0C, 32'h0);
		expect_eq(rd, 32'h0, "unmapped read");
		// Full stack withholds the interrupt until a return frees a level
		gie <= 1'b1;
		irq_req <= 1'b1;
		repeat (60) @(posedge pclk);
		expect_eq(n_acks, 0, "ack on full stack");
		u_cps_pmem_model.rom[12'h020] = 16'h8000;
		for (int i = 0; i < 200 && !(n_acks > 0 && fq.size() > 0); i++) @(negedge pclk);
		if (n_acks == 0) bad("no acknowledge after return");
		@(posedge pclk);
		irq_req <= 1'b0;
		gie <= 1'b0;
		expect_eq(fq[0], VEC, "vector fetch");
		// Low byte write jumps within the page
		for (int i = 0; i < 100 && pmem_addr[11:8] !== 4'h3; i++) @(negedge pclk);
		if (pmem_addr[11:8] !== 4'h3) bad("page not reached");
		apb(1'b1, PCLOW_OFS, 32'hA5);
		@(negedge pclk);
		fq.delete();
		wait_q(3);
		expect_eq({31'h0, fq[0] === 12'h3A5 || fq[1] === 12'h3A5}, 32'h1, "low byte jump");
		for (int k = 0; k < 3; k++) expect_eq(fq[k][11:8], 4'h3, "page kept");
		// ALU table; loop at 0x100 sends each result to memory
		for (int k = 0; k < 10; k++)
		begin
			apb(1'b1, ACC_OFS, {24'h0, av[k]});
			operand <= bv[k];
			u_cps_pmem_model.rom[12'h100] = {3'b001, 1'b0, ops[k], 8'h00};
			cnt = 0;
			for (int i = 0; i < 300 && cnt < 3; i++)
			begin
				@(negedge pclk);
				if (mem_wr === 1'b1) cnt++;
			end
			if (cnt < 3) bad("no alu write");
			expect_eq(mem_wdata, ev[k], "alu result");
			if (ops[k] == ALU_ADD) expect_eq(status_flags[C_BIT], 1'b1, "carry");
			if (ops[k] == ALU_INC) expect_eq(status_flags[Z_BIT], 1'b1, "zero");
		end
		finish_test();
	end

endmodule : tb

`default_nettype wire
